// ### atm_consts.svh
// Constants for the antenna trim and AM depth register block
//
// What this block does
// - Trim calibration result lands in bits 7..4
// - Trim source 0 drives switches from result
// - Trim failure sets bit 3 of result
// - Both result registers clear on reset/default
// - Depth control and segment mask reset zero
// - Depth control bit 7 picks keyed-level source
// - Six-bit depth setting in bits 6..1
// - Depth calibration outcome readable; ones disable segments
// - Failed depth calibration writes all ones
// - Manual mask bits disable segments, bit7 2 Ohm
// - Trim source 1 drives switches from manual bits
`ifndef ATM_CONSTS_SVH
`define ATM_CONSTS_SVH

`define ATM_DATA_W          8
`define ATM_IRQ_W           4

// ----------------------------------------------------------------
// Register indices; byte address is four times the index
// ----------------------------------------------------------------
`define ATM_IDX_TRIM_CTRL   8'h21
`define ATM_IDX_TUNE_RES    8'h23
`define ATM_IDX_DEPTH_CTRL  8'h24
`define ATM_IDX_DEPTH_RES   8'h25
`define ATM_IDX_SEG_MASK    8'h26
`define ATM_IDX_IRQ_STAT    8'h30
`define ATM_IDX_IRQ_MASK    8'h31

// ----------------------------------------------------------------
// Address decode fields
// ----------------------------------------------------------------
`define ATM_WIDX_HI         9
`define ATM_WIDX_LO         2
`define ATM_UPPER_LO        10
`define ATM_BYTE_HI         1

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ATM_TRIM_SRC_BIT    7
`define ATM_TRIM_MAN_HI     6
`define ATM_TRIM_MAN_LO     3
`define ATM_TUNE_VAL_HI     7
`define ATM_TUNE_VAL_LO     4
`define ATM_TUNE_ERR_BIT    3
`define ATM_TUNE_IN_HI      3
`define ATM_DEPTH_SRC_BIT   7
`define ATM_DEPTH_SET_HI    6
`define ATM_DEPTH_SET_LO    1
`define ATM_EV_ANT_DONE     0
`define ATM_EV_ANT_ERR      1
`define ATM_EV_DEPTH_DONE   2
`define ATM_EV_DEPTH_ERR    3

// ----------------------------------------------------------------
// Reset and fixed values
// ----------------------------------------------------------------
`define ATM_RST_BYTE        8'h00
`define ATM_ALL_ONES        8'hff
`define ATM_RST_TRIM        4'h0
`define ATM_RST_DEPTH       6'h00
`define ATM_RST_IRQ         4'h0
`define ATM_RST_WORD        32'h0000_0000

`endif

// ### atm_pkg.sv
// Types shared by the antenna trim and AM depth register block
`include "atm_consts.svh"

package atm_pkg;

	// One calibration sequence finishing: strobe, failure flag, result
	typedef struct packed {
		logic                   done;
		logic                   fail;
		logic [`ATM_DATA_W-1:0] value;
	} atm_cal_evt_s;

	// Bus address phase held over into the data phase
	typedef struct packed {
		logic       wr;
		logic       mapped;
		logic [7:0] idx;
	} atm_bus_phase_s;

endpackage : atm_pkg

// ### atm_regs.sv
// AHB-Lite register bank for antenna trim and AM modulation depth
//
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/1ps
`include "atm_consts.svh"

module atm_regs
	import atm_pkg::*;
(
	input  wire logic                   hclk,
	input  wire logic                   hresetn,
	input  wire logic                   clk_en,
	input  wire logic                   hsel,
	input  wire logic [31:0]            haddr,
	input  wire logic [1:0]             htrans,
	input  wire logic                   hwrite,
	input  wire logic [2:0]             hsize,
	input  wire logic [31:0]            hwdata,
	input  wire logic                   hready,
	output logic                        hreadyout,
	output logic                        hresp,
	output logic [31:0]                 hrdata,
	input  wire logic                   set_default,
	input  wire atm_cal_evt_s           ant_cal,
	input  wire atm_cal_evt_s           depth_cal,
	output logic [3:0]                  trim_switch_on,
	output logic [5:0]                  depth_setting,
	output logic [`ATM_DATA_W-1:0]      keyed_segment_off,
	output logic                        irq
);

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	logic                   trim_src_reg;
	logic [3:0]             trim_manual_reg;
	logic [3:0]             tune_val_reg;
	logic                   tune_err_reg;
	logic                   keyed_level_source_select_reg;
	logic [5:0]             depth_set_reg;
	logic [`ATM_DATA_W-1:0] depth_result_reg;
	logic [`ATM_DATA_W-1:0] seg_mask_reg;
	logic [`ATM_IRQ_W-1:0]  irq_stat_reg;
	logic [`ATM_IRQ_W-1:0]  irq_mask_reg;
	atm_bus_phase_s         phase_reg;
	logic                   wr_pend_reg;
	logic [31:0]            hrdata_reg;
	logic [3:0]             trim_out_reg;
	logic [`ATM_DATA_W-1:0] seg_out_reg;
	logic                   irq_reg;

	// ----------------------------------------------------------------
	// Address phase decode
	// ----------------------------------------------------------------
	wire                    acc_take;
	wire                    acc_mapped;
	wire [7:0]              acc_idx;
	wire                    rd_take;
	wire                    hit_trim_ctrl;
	wire                    hit_tune_res;
	wire                    hit_depth_ctrl;
	wire                    hit_depth_res;
	wire                    hit_seg_mask;
	wire                    hit_irq_stat;
	wire                    hit_irq_mask;

	// The bus stalls while the block is frozen so no transfer is lost
	assign hreadyout = clk_en;
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_reg;

	assign acc_take   = hsel & htrans[1] & hready;
	assign acc_idx    = haddr[`ATM_WIDX_HI:`ATM_WIDX_LO];
	assign acc_mapped = (haddr[31:`ATM_UPPER_LO] == '0) & (haddr[`ATM_BYTE_HI:0] == 2'b00);
	assign rd_take    = acc_take & ~hwrite & acc_mapped;

	assign hit_trim_ctrl  = (acc_idx == `ATM_IDX_TRIM_CTRL);
	assign hit_tune_res   = (acc_idx == `ATM_IDX_TUNE_RES);
	assign hit_depth_ctrl = (acc_idx == `ATM_IDX_DEPTH_CTRL);
	assign hit_depth_res  = (acc_idx == `ATM_IDX_DEPTH_RES);
	assign hit_seg_mask   = (acc_idx == `ATM_IDX_SEG_MASK);
	assign hit_irq_stat   = (acc_idx == `ATM_IDX_IRQ_STAT);
	assign hit_irq_mask   = (acc_idx == `ATM_IDX_IRQ_MASK);

	// ----------------------------------------------------------------
	// Read data assembly
	// ----------------------------------------------------------------
	wire [`ATM_DATA_W-1:0]  rd_trim_ctrl;
	wire [`ATM_DATA_W-1:0]  rd_tune_res;
	wire [`ATM_DATA_W-1:0]  rd_depth_ctrl;
	wire [`ATM_DATA_W-1:0]  rd_byte;
	wire [31:0]             rd_word;

	// Only implemented fields are stored, so spare bits read as zero
	assign rd_trim_ctrl  = {trim_src_reg, trim_manual_reg, 3'b000};
	assign rd_tune_res   = {tune_val_reg, tune_err_reg, 3'b000};
	assign rd_depth_ctrl = {keyed_level_source_select_reg, depth_set_reg, 1'b0};

	assign rd_byte = hit_trim_ctrl  ? rd_trim_ctrl :
	                 hit_tune_res   ? rd_tune_res :
	                 hit_depth_ctrl ? rd_depth_ctrl :
	                 hit_depth_res  ? depth_result_reg :
	                 hit_seg_mask   ? seg_mask_reg :
	                 hit_irq_stat   ? {4'h0, irq_stat_reg} :
	                 hit_irq_mask   ? {4'h0, irq_mask_reg} :
	                 `ATM_RST_BYTE;
	assign rd_word = {24'h00_0000, rd_byte};

	// ----------------------------------------------------------------
	// Data phase write strobes
	// ----------------------------------------------------------------
	wire                    wr_ok;
	wire                    wr_trim_ctrl;
	wire                    wr_depth_ctrl;
	wire                    wr_seg_mask;
	wire                    wr_irq_mask;
	wire [`ATM_DATA_W-1:0]  wbyte;

	assign wr_ok         = wr_pend_reg & phase_reg.mapped;
	assign wbyte         = hwdata[`ATM_DATA_W-1:0];
	assign wr_trim_ctrl  = wr_ok & (phase_reg.idx == `ATM_IDX_TRIM_CTRL);
	assign wr_depth_ctrl = wr_ok & (phase_reg.idx == `ATM_IDX_DEPTH_CTRL);
	assign wr_seg_mask   = wr_ok & (phase_reg.idx == `ATM_IDX_SEG_MASK);
	assign wr_irq_mask   = wr_ok & (phase_reg.idx == `ATM_IDX_IRQ_MASK);

	// ----------------------------------------------------------------
	// Bus phase pipeline and read data
	// ----------------------------------------------------------------
	// Read data is captured in the address phase; a read whose address
	// phase overlaps the data phase of a write to the same register
	// returns the value from before that write
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			phase_reg   <= '0;
			wr_pend_reg <= 1'b0;
			hrdata_reg  <= `ATM_RST_WORD;
		end else if (clk_en) begin
			wr_pend_reg <= acc_take & hwrite;
			phase_reg   <= '{wr: hwrite, mapped: acc_mapped, idx: acc_idx};
			if (rd_take) begin
				hrdata_reg <= rd_word;
			end
		end
	end

	// ----------------------------------------------------------------
	// Trim calibration control and result
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			trim_src_reg    <= 1'b0;
			trim_manual_reg <= `ATM_RST_TRIM;
			tune_val_reg    <= `ATM_RST_TRIM;
			tune_err_reg    <= 1'b0;
		end else if (clk_en) begin
			if (set_default) begin
				trim_src_reg    <= 1'b0;
				trim_manual_reg <= `ATM_RST_TRIM;
				tune_val_reg    <= `ATM_RST_TRIM;
				tune_err_reg    <= 1'b0;
			end else begin
				if (wr_trim_ctrl) begin
					trim_src_reg    <= wbyte[`ATM_TRIM_SRC_BIT];
					trim_manual_reg <= wbyte[`ATM_TRIM_MAN_HI:`ATM_TRIM_MAN_LO];
				end
				if (ant_cal.done) begin
					tune_val_reg <= ant_cal.value[`ATM_TUNE_IN_HI:0];
					tune_err_reg <= ant_cal.fail;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// AM depth control, result and manual segment mask
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			keyed_level_source_select_reg <= 1'b0;
			depth_set_reg                 <= `ATM_RST_DEPTH;
			depth_result_reg              <= `ATM_RST_BYTE;
			seg_mask_reg                  <= `ATM_RST_BYTE;
		end else if (clk_en) begin
			if (set_default) begin
				keyed_level_source_select_reg <= 1'b0;
				depth_set_reg                 <= `ATM_RST_DEPTH;
				depth_result_reg              <= `ATM_RST_BYTE;
				seg_mask_reg                  <= `ATM_RST_BYTE;
			end else begin
				if (wr_depth_ctrl) begin
					keyed_level_source_select_reg <= wbyte[`ATM_DEPTH_SRC_BIT];
					depth_set_reg <= wbyte[`ATM_DEPTH_SET_HI:`ATM_DEPTH_SET_LO];
				end
				if (wr_seg_mask) begin
					seg_mask_reg <= wbyte;
				end
				if (depth_cal.done) begin
					// A failed run must not leave a half-trimmed pattern behind
					depth_result_reg <= depth_cal.fail ? `ATM_ALL_ONES : depth_cal.value;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Drive outputs toward the analog front end
	// ----------------------------------------------------------------
	wire [3:0]              trim_next;
	wire [`ATM_DATA_W-1:0]  seg_next;

	assign trim_next = trim_src_reg ? trim_manual_reg : tune_val_reg;
	assign seg_next  = keyed_level_source_select_reg ? seg_mask_reg : depth_result_reg;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			trim_out_reg <= `ATM_RST_TRIM;
			seg_out_reg  <= `ATM_RST_BYTE;
		end else if (clk_en) begin
			trim_out_reg <= trim_next;
			seg_out_reg  <= seg_next;
		end
	end

	assign trim_switch_on    = trim_out_reg;
	assign keyed_segment_off = seg_out_reg;
	assign depth_setting     = depth_set_reg;

	// ----------------------------------------------------------------
	// Interrupt status and mask
	// ----------------------------------------------------------------
	wire [`ATM_IRQ_W-1:0]   ev_set;
	wire                    stat_rd_clr;

	assign ev_set[`ATM_EV_ANT_DONE]   = ant_cal.done;
	assign ev_set[`ATM_EV_ANT_ERR]    = ant_cal.done & ant_cal.fail;
	assign ev_set[`ATM_EV_DEPTH_DONE] = depth_cal.done;
	assign ev_set[`ATM_EV_DEPTH_ERR]  = depth_cal.done & depth_cal.fail;
	assign stat_rd_clr                = rd_take & hit_irq_stat;

	// A new event in the cycle of the clearing read survives it
	genvar gi;
	generate
		for (gi = 0; gi < `ATM_IRQ_W; gi = gi + 1) begin : g_stat
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					irq_stat_reg[gi] <= 1'b0;
				end else if (clk_en) begin
					if (ev_set[gi]) begin
						irq_stat_reg[gi] <= 1'b1;
					end else if (stat_rd_clr) begin
						irq_stat_reg[gi] <= 1'b0;
					end
				end
			end
		end
	endgenerate

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_mask_reg <= `ATM_RST_IRQ;
			irq_reg      <= 1'b0;
		end else if (clk_en) begin
			if (wr_irq_mask) begin
				irq_mask_reg <= wbyte[`ATM_IRQ_W-1:0];
			end
			irq_reg <= |(irq_stat_reg & irq_mask_reg);
		end
	end

	assign irq = irq_reg;

	// Transfer size is not checked: only whole-word access is supported
	wire unused_ok = &{1'b0, hsize, hwdata[31:`ATM_DATA_W], phase_reg.wr};

endmodule : atm_regs

// ### atm_regs_sva.sv
// Checker for the antenna trim and AM depth register bank
`timescale 1ns/1ps
`include "atm_consts.svh"
module atm_regs_chk
	import atm_pkg::*;
(
	input wire logic                   hclk,
	input wire logic                   hresetn,
	input wire logic                   clk_en,
	input wire logic                   hsel,
	input wire logic [31:0]            haddr,
	input wire logic [1:0]             htrans,
	input wire logic                   hwrite,
	input wire logic [2:0]             hsize,
	input wire logic [31:0]            hwdata,
	input wire logic                   hready,
	input wire logic                   hreadyout,
	input wire logic                   hresp,
	input wire logic [31:0]            hrdata,
	input wire logic                   set_default,
	input wire atm_cal_evt_s           ant_cal,
	input wire atm_cal_evt_s           depth_cal,
	input wire logic [3:0]             trim_switch_on,
	input wire logic [5:0]             depth_setting,
	input wire logic [`ATM_DATA_W-1:0] keyed_segment_off,
	input wire logic                   irq
);
	logic tk;
	logic wp;
	assign tk = hsel & htrans[1] & hready & clk_en;
	// Remembers a write in its data phase; a status read also moves a register by clearing it
	always_ff @(posedge hclk or negedge hresetn) begin
		// Held while frozen, like the bank's own pending-write flag
		if (!hresetn) wp <= 1'b0;
		else if (clk_en) wp <= tk & hwrite;
	end
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn || !clk_en);
	property p_resp; hresp == 1'b0; endproperty
	a_resp: assert property (p_resp) else $error("error response seen");
	property p_rdy; hreadyout == clk_en; endproperty
	a_rdy: assert property (p_rdy) else $error("ready not following enable");
	property p_up; hrdata[31:8] == 24'h0; endproperty
	a_up: assert property (p_up) else $error("upper read bits set");
	property p_dflt;
		set_default |=> depth_setting == 6'h00 ##1
			(trim_switch_on == 4'h0 && keyed_segment_off == 8'h00);
	endproperty
	a_dflt: assert property (p_dflt) else $error("default not cleared");
	property p_dep; $changed(depth_setting) |-> $past(wp) || $past(set_default); endproperty
	a_dep: assert property (p_dep) else $error("depth moved alone");
	property p_seg;
		$changed(keyed_segment_off) |-> $past(wp | depth_cal.done | set_default, 2);
	endproperty
	a_seg: assert property (p_seg) else $error("segments moved alone");
	property p_trim;
		$changed(trim_switch_on) |-> $past(wp | ant_cal.done | set_default, 2);
	endproperty
	a_trim: assert property (p_trim) else $error("trim moved alone");
	property p_irq;
		$changed(irq) |-> $past(wp | ant_cal.done | depth_cal.done | (tk & !hwrite), 2);
	endproperty
	a_irq: assert property (p_irq) else $error("irq moved alone");
	c_irq: cover property ($rose(irq));
	c_dflt: cover property (set_default);
	c_fail: cover property (depth_cal.done && depth_cal.fail);
endmodule : atm_regs_chk

bind atm_regs atm_regs_chk i_chk (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en),
	.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
	.hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
	.hrdata(hrdata), .set_default(set_default), .ant_cal(ant_cal), .depth_cal(depth_cal),
	.trim_switch_on(trim_switch_on), .depth_setting(depth_setting),
	.keyed_segment_off(keyed_segment_off), .irq(irq));

// ### tb_top.sv
// Self-checking bench for the antenna trim and AM depth register bank
`timescale 1ns/1ps
`include "atm_consts.svh"
module tb_top
	import atm_pkg::*;
;
	logic         hclk, hresetn, clk_en, hsel, hwrite, hready, set_default;
	logic         hreadyout, hresp, irq;
	logic [31:0]  haddr, hwdata, hrdata, seed, r;
	logic [1:0]   htrans;
	logic [2:0]   hsize;
	logic [3:0]   trim_switch_on, mk, st;
	logic [5:0]   depth_setting;
	logic [7:0]   keyed_segment_off, tc, dc, sm, tr, dr;
	atm_cal_evt_s ant_cal, depth_cal;
	int           errors, checked;
	assign hready = hreadyout;
	atm_regs i_dut (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.set_default(set_default), .ant_cal(ant_cal), .depth_cal(depth_cal),
		.trim_switch_on(trim_switch_on), .depth_setting(depth_setting),
		.keyed_segment_off(keyed_segment_off), .irq(irq));
	initial begin
		hclk = 1'b0;
		forever #50 hclk = ~hclk;
	end
	function automatic logic [31:0] xr();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xr
	function automatic logic [3:0] e_trim(); return tc[7] ? tc[6:3] : tr[7:4]; endfunction : e_trim
	function automatic logic [7:0] e_seg(); return dc[7] ? sm : dr; endfunction : e_seg
	task automatic cmp(input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			errors++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : cmp
	task automatic report_and_stop();
		$display("checked=%0d errors=%0d", checked, errors);
		if (errors == 0 && checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : report_and_stop
	task automatic rdy();
		int n;
		n = 0;
		@(posedge hclk);
		while (hready !== 1'b1) begin
			if (++n > 20) begin
				errors++;
				report_and_stop();
			end
			@(posedge hclk);
		end
	endtask : rdy
	// One single transfer; a read compares hrdata at the data-phase edge
	task automatic bus(input logic w, input logic [7:0] ix, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {22'h0, ix, 2'b00};
		htrans <= 2'b10;
		hwrite <= w;
		rdy();
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		rdy();
		cmp({31'h0, hresp}, 32'h0);
		if (!w) cmp(hrdata, d);
	endtask : bus
	// A calibration finishing; the extra edge keeps strobes from abutting
	task automatic cal(input logic a, input logic f, input logic [7:0] v);
		if (a) ant_cal <= '{1'b1, f, v};
		else depth_cal <= '{1'b1, f, v};
		@(posedge hclk);
		ant_cal <= '0;
		depth_cal <= '0;
		@(posedge hclk);
		if (a) tr = {v[3:0], f, 3'b000};
		else dr = f ? 8'hff : v;
		st |= a ? {2'b00, f, 1'b1} : {f, 1'b1, 2'b00};
	endtask : cal
	task automatic chk();
		bus(1'b0, `ATM_IDX_TRIM_CTRL, {24'h0, tc});
		bus(1'b0, `ATM_IDX_TUNE_RES, {24'h0, tr});
		bus(1'b0, `ATM_IDX_DEPTH_CTRL, {24'h0, dc});
		bus(1'b0, `ATM_IDX_DEPTH_RES, {24'h0, dr});
		bus(1'b0, `ATM_IDX_SEG_MASK, {24'h0, sm});
		bus(1'b0, `ATM_IDX_IRQ_MASK, {28'h0, mk});
		bus(1'b0, 8'h27, 32'h0);
		cmp({28'h0, trim_switch_on}, {28'h0, e_trim()});
		cmp({24'h0, keyed_segment_off}, {24'h0, e_seg()});
		cmp({26'h0, depth_setting}, {26'h0, dc[6:1]});
		cmp({31'h0, irq}, {31'h0, |(st & mk)});
	endtask : chk
	initial begin
		{hresetn, hsel, hwrite, set_default, htrans, haddr, hwdata} = '0;
		{tc, dc, sm, tr, dr, mk, st, ant_cal, depth_cal} = '0;
		clk_en = 1'b1;
		hsize = 3'b010;
		seed = 32'heff85d5f;
		errors = 0;
		checked = 0;
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		chk();
		$display("test reset done");
		repeat (60) begin
			r = xr();
			case (r[2:0])
			3'd0: begin
				bus(1'b1, `ATM_IDX_TRIM_CTRL, r[15:8]);
				tc = r[15:8] & 8'hf8;
			end
			3'd1: begin
				bus(1'b1, `ATM_IDX_DEPTH_CTRL, r[15:8]);
				dc = r[15:8] & 8'hfe;
			end
			3'd2: begin
				bus(1'b1, `ATM_IDX_SEG_MASK, r[15:8]);
				sm = r[15:8];
			end
			3'd3: cal(1'b1, r[16], r[15:8]);
			3'd4: cal(1'b0, r[16] & r[17], r[15:8]);
			3'd5: begin
				bus(1'b1, `ATM_IDX_IRQ_MASK, r[15:8]);
				mk = r[11:8];
			end
			3'd6: begin
				bus(1'b0, `ATM_IDX_IRQ_STAT, {28'h0, st});
				st = 4'h0;
			end
			default: bus(1'b1, r[16] ? `ATM_IDX_TUNE_RES : `ATM_IDX_DEPTH_RES, r[15:8]);
			endcase
			chk();
		end
		$display("test random done");
		cal(1'b0, 1'b1, 8'h00);
		bus(1'b1, `ATM_IDX_DEPTH_CTRL, 32'hffff_ffff);
		bus(1'b1, `ATM_IDX_TRIM_CTRL, 32'h0000_00ff);
		{dc, tc} = {8'hfe, 8'hf8};
		chk();
		set_default <= 1'b1;
		@(posedge hclk);
		set_default <= 1'b0;
		@(posedge hclk);
		{tc, dc, sm, tr, dr} = '0;
		chk();
		// Calibration done held through the clearing status read and the cycle after it: status ends set
		ant_cal <= '{1'b1, 1'b0, 8'h5a};
		bus(1'b0, `ATM_IDX_IRQ_STAT, {28'h0, st});
		ant_cal <= '0;
		{st, tr} = {4'h1, 8'ha0};
		chk();
		// A strobe while frozen is lost and the bus reports not ready
		clk_en <= 1'b0;
		depth_cal <= '{1'b1, 1'b1, 8'h3c};
		@(posedge hclk);
		cmp({31'h0, hready}, 32'h0);
		depth_cal <= '0;
		clk_en <= 1'b1;
		@(posedge hclk);
		chk();
		$display("test corner done");
		report_and_stop();
	end
endmodule : tb_top
